// ### design/lic_map.svh
// Offsets, field positions, reset values and timing counts of the line interface test and interrupt block.
// Assumes inclusion by bare name from the block's design file.
//
// Functional notes
// [R01] With pattern select 100, each 0-to-1 of insert bit corrupts one QRSS bit.
// [R02] Insert bit is sampled on rising edges of the transmit clock.
// [R03] Software writes zero to the insert bit before writing one.
// [R04] Drive monitor enable: interrupt on every change of drive monitor status.
// [R05] FIFO limit enable: interrupt when jitter FIFO pointers come within three.
// [R06] Loop code enable: interrupt when loop code detection starts and stops.
// [R07] Enable bits 6, 5, 3 gate their interrupts; all reset to zero.
// [R08] Bits 7, 4, 2 of enables and bit 0 of control three unused; 7 reads 0.
// [R09] Loop code status sets after code persists five seconds; interrupt only if enabled.
// [R10] Enables, status and interrupts work only in single rail operation; code gates only interrupt status setting and irq, live status runs in any mode.
// [R11] Each source uses an edge detector; request only while its enable is one.
`ifndef LIC_MAP_SVH
`define LIC_MAP_SVH

// Byte addresses
`define LIC_CTRL3_ADDR 16'h0f00
`define LIC_IRQ_EN_ADDR 16'h0f04
`define LIC_IRQ_STAT_ADDR 16'h0f08
`define LIC_LIVE_STAT_ADDR 16'h0f0c
`define LIC_TEST_SEL_ADDR 16'h0f10

// Field positions
`define LIC_CTRL3_SPARE_BIT 0
`define LIC_CTRL3_INSERT_BIT 1
`define LIC_DRIVE_BIT 6
`define LIC_FIFO_BIT 5
`define LIC_LOOP_BIT 3
`define LIC_IRQ_MASK 8'h68
`define LIC_CTRL3_MASK 8'h03

// Reset values
`define LIC_CTRL3_RESET 8'h00
`define LIC_IRQ_EN_RESET 8'h00
`define LIC_IRQ_STAT_RESET 8'h00
`define LIC_TEST_SEL_RESET 3'h0

// Jitter attenuator pointer width and nearness limit
`define LIC_PTR_W 7
`define LIC_PTR_LIMIT 7'h03

// Timing
`define LIC_CLK_HZ 10000000
`define LIC_LOOP_PERSIST_S 5
`define LIC_LOOP_PERSIST_CYCLES (`LIC_LOOP_PERSIST_S * `LIC_CLK_HZ)
`define LIC_LOOP_CNT_W 26

`endif

// ### design/lic_pkg.sv
// Types of the line interface test and interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package lic_pkg;

   typedef enum logic [2:0] {
      LIC_PAT_NONE = 3'h0,
      LIC_PAT_ALT1 = 3'h1,
      LIC_PAT_ALT2 = 3'h2,
      LIC_PAT_ALT3 = 3'h3,
      LIC_PAT_QRSS = 3'h4,
      LIC_PAT_ALT5 = 3'h5,
      LIC_PAT_ALT6 = 3'h6,
      LIC_PAT_ALT7 = 3'h7
   } lic_pattern_t;

   typedef logic [7:0] lic_byte_t;
   typedef logic [31:0] lic_word_t;
   typedef logic [15:0] lic_addr_t;

endpackage

// ### design/lic_top.sv
// Line interface control: QRSS single bit error insertion and change-of-state interrupts behind APB.
// Assumes pins and transmit-side signals arrive asynchronously; pointers come from pclk logic.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.svh"

module lic_top #(
   parameter int unsigned LOOP_PERSIST_CYCLES = `LIC_LOOP_PERSIST_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire lic_pkg::lic_addr_t paddr,
   input wire lic_pkg::lic_word_t pwdata,
   output logic pready,
   output logic pslverr,
   output lic_pkg::lic_word_t prdata,
   // Transmit side
   input wire logic tx_clock,
   input wire logic qrss_pattern_bit,
   output logic tx_data,
   output logic tx_error_inserted,
   // Status sources
   input wire logic drive_monitor_status,
   input wire logic loop_code_match,
   input wire logic single_rail_mode,
   input wire logic [`LIC_PTR_W-1:0] ja_rd_ptr,
   input wire logic [`LIC_PTR_W-1:0] ja_wr_ptr,
   // Results
   output logic loop_code_detect_status,
   output logic irq
);
   import lic_pkg::*;

   localparam int SYNC_W = 5;
   localparam int S_TXCLK = 0;
   localparam int S_QRSS = 1;
   localparam int S_DRIVE = 2;
   localparam int S_LOOP = 3;
   localparam int S_RAIL = 4;
   localparam logic [`LIC_LOOP_CNT_W-1:0] PERSIST_LAST =
      `LIC_LOOP_CNT_W'(LOOP_PERSIST_CYCLES - 1);

   function automatic logic rose(input logic now, input logic prev);
      rose = now & ~prev;
   endfunction

   function automatic logic changed(input logic now, input logic prev);
      changed = now ^ prev;
   endfunction

   function automatic logic ptr_near(input logic [`LIC_PTR_W-1:0] wr,
                                     input logic [`LIC_PTR_W-1:0] rd);
      logic [`LIC_PTR_W-1:0] gap;
      gap = wr - rd;
      ptr_near = (gap <= `LIC_PTR_LIMIT) || ((rd - wr) <= `LIC_PTR_LIMIT);
   endfunction

   // Input synchronisers
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [SYNC_W-1:0] next_sync1;
   logic [SYNC_W-1:0] next_sync2;

   always_comb begin
      next_sync1 = {single_rail_mode, loop_code_match, drive_monitor_status,
                    qrss_pattern_bit, tx_clock};
      next_sync2 = sync1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   logic rail_ok;
   assign rail_ok = sync2[S_RAIL];

   // Register file state
   lic_byte_t ctrl3;
   lic_byte_t irq_en;
   lic_byte_t irq_stat;
   lic_pattern_t test_sel;
   lic_byte_t next_ctrl3;
   lic_byte_t next_irq_en;
   lic_byte_t next_irq_stat;
   lic_pattern_t next_test_sel;

   logic wr_en;
   logic rd_en;
   logic hit;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   always_comb begin
      unique case (paddr)
         `LIC_CTRL3_ADDR,
         `LIC_IRQ_EN_ADDR,
         `LIC_IRQ_STAT_ADDR,
         `LIC_LIVE_STAT_ADDR,
         `LIC_TEST_SEL_ADDR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Transmit clock edge and error insertion
   logic tx_clk_prev;
   logic insert_prev;
   logic tx_data_q;
   logic tx_err_q;
   logic next_tx_clk_prev;
   logic next_insert_prev;
   logic next_tx_data;
   logic next_tx_err;
   logic tx_rise;
   logic insert_now;

   always_comb begin
      tx_rise = rose(sync2[S_TXCLK], tx_clk_prev);
      insert_now = ctrl3[`LIC_CTRL3_INSERT_BIT];
      next_tx_clk_prev = sync2[S_TXCLK];
      next_insert_prev = insert_prev;
      next_tx_data = tx_data_q;
      next_tx_err = 1'b0;
      if (tx_rise) begin
         next_insert_prev = insert_now; // R02
         next_tx_data = sync2[S_QRSS];
         if (test_sel == LIC_PAT_QRSS && rose(insert_now, insert_prev)) begin
            next_tx_data = ~sync2[S_QRSS]; // R01
            next_tx_err = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_clk_prev <= 1'b0;
         insert_prev <= 1'b0;
         tx_data_q <= 1'b0;
         tx_err_q <= 1'b0;
      end else begin
         tx_clk_prev <= next_tx_clk_prev;
         insert_prev <= next_insert_prev;
         tx_data_q <= next_tx_data;
         tx_err_q <= next_tx_err;
      end
   end

   assign tx_data = tx_data_q;
   assign tx_error_inserted = tx_err_q;

   // Loop code persistence
   logic [`LIC_LOOP_CNT_W-1:0] loop_cnt;
   logic loop_status;
   logic [`LIC_LOOP_CNT_W-1:0] next_loop_cnt;
   logic next_loop_status;

   always_comb begin
      next_loop_cnt = loop_cnt;
      next_loop_status = loop_status;
      if (!sync2[S_LOOP]) begin
         next_loop_cnt = '0;
         next_loop_status = 1'b0;
      end else if (!loop_status) begin
         if (loop_cnt == PERSIST_LAST) begin
            next_loop_status = 1'b1; // R09
         end else begin
            next_loop_cnt = loop_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_cnt <= '0;
         loop_status <= 1'b0;
      end else begin
         loop_cnt <= next_loop_cnt;
         loop_status <= next_loop_status;
      end
   end

   assign loop_code_detect_status = loop_status;

   // Change detectors
   logic drive_prev;
   logic fifo_near;
   logic fifo_prev;
   logic loop_prev;
   logic next_drive_prev;
   logic next_fifo_prev;
   logic next_loop_prev;
   logic [7:0] event_vec;

   always_comb begin
      fifo_near = ptr_near(ja_wr_ptr, ja_rd_ptr); // R05
      next_drive_prev = sync2[S_DRIVE];
      next_fifo_prev = fifo_near;
      next_loop_prev = loop_status;
      event_vec = '0;
      event_vec[`LIC_DRIVE_BIT] = changed(sync2[S_DRIVE], drive_prev); // R04 R11
      event_vec[`LIC_FIFO_BIT] = rose(fifo_near, fifo_prev); // R05 R11
      event_vec[`LIC_LOOP_BIT] = changed(loop_status, loop_prev); // R06 R11
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_prev <= 1'b0;
         fifo_prev <= 1'b0;
         loop_prev <= 1'b0;
      end else begin
         drive_prev <= next_drive_prev;
         fifo_prev <= next_fifo_prev;
         loop_prev <= next_loop_prev;
      end
   end

   // Register updates
   lic_byte_t set_vec;

   always_comb begin
      set_vec = event_vec & irq_en & {8{rail_ok}}; // R10 R11
      next_ctrl3 = ctrl3;
      next_irq_en = irq_en;
      next_test_sel = test_sel;
      next_irq_stat = irq_stat;
      if (wr_en) begin
         unique case (paddr)
            `LIC_CTRL3_ADDR: begin
               next_ctrl3 = pwdata[7:0] & `LIC_CTRL3_MASK; // R08
            end
            `LIC_IRQ_EN_ADDR: begin
               next_irq_en = pwdata[7:0] & `LIC_IRQ_MASK; // R07 R08
            end
            `LIC_IRQ_STAT_ADDR: begin
               next_irq_stat = irq_stat & ~pwdata[7:0];
            end
            `LIC_TEST_SEL_ADDR: begin
               next_test_sel = lic_pattern_t'(pwdata[2:0]);
            end
            default: begin
               next_ctrl3 = ctrl3;
            end
         endcase
      end
      next_irq_stat = (next_irq_stat | set_vec) & `LIC_IRQ_MASK;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl3 <= `LIC_CTRL3_RESET;
         irq_en <= `LIC_IRQ_EN_RESET; // R07
         irq_stat <= `LIC_IRQ_STAT_RESET;
         test_sel <= lic_pattern_t'(`LIC_TEST_SEL_RESET);
      end else begin
         ctrl3 <= next_ctrl3;
         irq_en <= next_irq_en;
         irq_stat <= next_irq_stat;
         test_sel <= next_test_sel;
      end
   end

   // Read data and interrupt output
   lic_word_t rdata_q;
   lic_word_t next_rdata;
   logic irq_q;
   logic next_irq;
   lic_byte_t live_vec;

   always_comb begin
      live_vec = '0;
      live_vec[`LIC_DRIVE_BIT] = sync2[S_DRIVE];
      live_vec[`LIC_FIFO_BIT] = fifo_near;
      live_vec[`LIC_LOOP_BIT] = loop_status;
      next_rdata = '0;
      if (psel & ~penable & ~pwrite) begin
         unique case (paddr)
            `LIC_CTRL3_ADDR: next_rdata = {24'h000000, ctrl3};
            `LIC_IRQ_EN_ADDR: next_rdata = {24'h000000, irq_en};
            `LIC_IRQ_STAT_ADDR: next_rdata = {24'h000000, irq_stat};
            `LIC_LIVE_STAT_ADDR: next_rdata = {24'h000000, live_vec};
            `LIC_TEST_SEL_ADDR: next_rdata = {29'h0, test_sel};
            default: next_rdata = '0;
         endcase
      end else if (rd_en) begin
         next_rdata = rdata_q;
      end
      next_irq = rail_ok & (|(next_irq_stat & next_irq_en)); // R07 R10
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= next_rdata;
         irq_q <= next_irq;
      end
   end

   assign prdata = rdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign irq = irq_q;

endmodule // lic_top

`default_nettype wire

// ### test/lic_assertions.sv
// Checker of the line interface block, watching the ports of lic_top.
// Assumes the map header on the include path and lic_top as bind target.
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.svh"
module lic_assertions import lic_pkg::*; #(
   parameter int unsigned LOOP_PERSIST_CYCLES = 20
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire lic_pkg::lic_addr_t paddr,
   input wire lic_pkg::lic_word_t pwdata,
   input wire logic pslverr,
   input wire lic_pkg::lic_word_t prdata,
   // Transmit and status
   input wire logic tx_error_inserted,
   input wire logic drive_monitor_status,
   input wire logic loop_code_match,
   input wire logic single_rail_mode,
   input wire logic [`LIC_PTR_W-1:0] ja_rd_ptr,
   input wire logic [`LIC_PTR_W-1:0] ja_wr_ptr,
   input wire logic loop_code_detect_status,
   input wire logic irq
);
   lic_byte_t en;
   lic_byte_t next_en;
   int unsigned run;
   int unsigned next_run;
   logic [`LIC_PTR_W-1:0] dif;
   logic near;
   logic rd_en;
   always_comb begin
      next_en = en;
      if (psel && penable && pwrite && paddr == `LIC_IRQ_EN_ADDR) begin
         next_en = pwdata[7:0] & `LIC_IRQ_MASK;
      end
      next_run = loop_code_match ? run + 1 : 0;
      dif = ja_wr_ptr - ja_rd_ptr;
      near = dif <= 7'h03 || dif >= 7'h7d;
      rd_en = psel && penable && !pwrite && paddr == `LIC_IRQ_EN_ADDR;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 8'h00;
         run <= 0;
      end else begin
         en <= next_en;
         run <= next_run;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_err_single: assert property (tx_error_inserted |=> !tx_error_inserted)
      else $error("insert pulse longer than one cycle");
   a_unmapped_read: assert property (psel && penable && !(paddr inside {16'h0f00, 16'h0f04, 16'h0f08,
      16'h0f0c, 16'h0f10}) |-> pslverr && prdata == 32'h0) else $error("unmapped access answered");
   a_en_readback: assert property (rd_en |-> prdata == {24'h0, en})
      else $error("enable readback wrong");
   a_rail_off: assert property (!single_rail_mode [*4] |-> !irq)
      else $error("irq outside single rail");
   a_loop_clear: assert property (!loop_code_match [*4] |-> !loop_code_detect_status)
      else $error("loop status stuck");
   a_loop_persist: assert property ($rose(loop_code_detect_status) |-> run >= LOOP_PERSIST_CYCLES)
      else $error("loop status set early");
   a_drive_irq: assert property (en[6] && single_rail_mode && $changed(drive_monitor_status) |-> ##[1:5] irq)
      else $error("drive monitor change lost");
   a_fifo_irq: assert property (en[5] && single_rail_mode && $rose(near) |-> ##[1:3] irq)
      else $error("fifo limit event lost");
   a_loop_irq: assert property (en[3] && single_rail_mode && $changed(loop_code_detect_status) |-> ##[1:3] irq)
      else $error("loop change lost");
   a_en_block: assert property (en == 8'h00 |-> !irq)
      else $error("irq without enable");
   c_insert: cover property (tx_error_inserted);
   c_loop: cover property ($rose(loop_code_detect_status));
   c_fifo: cover property (irq && en[5]);
endmodule // lic_assertions
bind lic_top lic_assertions #(.LOOP_PERSIST_CYCLES(LOOP_PERSIST_CYCLES)) chk (.*);
`default_nettype wire

// ### test/line_iface_test_and_irq_enables_test.sv
// Self-checking bench of lic_top over APB with expectations worked out here.
// Assumes the design files and the checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "lic_map.svh"
module line_iface_test_and_irq_enables_test;
   import lic_pkg::*;
   localparam int unsigned PERSIST = 20;
   localparam lic_addr_t CR = `LIC_CTRL3_ADDR;
   localparam lic_addr_t EN = `LIC_IRQ_EN_ADDR;
   localparam lic_addr_t ST = `LIC_IRQ_STAT_ADDR;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic tx_clock, qrss_pattern_bit, tx_data, tx_error_inserted;
   logic drive_monitor_status, loop_code_match, single_rail_mode, loop_code_detect_status, irq;
   lic_addr_t paddr;
   lic_word_t pwdata, prdata, rd;
   logic [6:0] ja_rd_ptr, ja_wr_ptr;
   logic [3:0] tcnt;
   logic [31:0] seed;
   int n_mismatch, tests_run, pulses, p0;
   lic_top #(.LOOP_PERSIST_CYCLES(PERSIST)) DUT (.*);
   always #50 pclk = ~pclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input lic_word_t s, input lic_word_t e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input lic_addr_t a, input lic_word_t d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rchk(input lic_addr_t a, input lic_word_t e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task clr(input lic_word_t b);
      rchk(ST, b);
      chk({31'h0, irq}, {31'h0, b != 0});
      apb(1'b1, ST, b);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task wrap_up;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Transmit clock of 16 pclk periods, pattern bit changed at its fall
   always @(posedge pclk) begin
      tcnt <= tcnt + 4'h1;
      tx_clock <= tcnt[3];
      if (tcnt == 4'h0) begin
         seed <= lfsr(seed);
         qrss_pattern_bit <= seed[0];
      end
      if (tx_error_inserted) begin
         pulses <= pulses + 1;
         chk({31'h0, tx_data}, {31'h0, ~qrss_pattern_bit});
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      wrap_up;
   end
   initial begin
      {presetn, psel, penable, pwrite, tx_clock, qrss_pattern_bit} = 6'h0;
      {drive_monitor_status, loop_code_match, single_rail_mode} = 3'h1;
      {paddr, pwdata, tcnt, ja_rd_ptr, ja_wr_ptr} = {16'h0, 32'h0, 4'h0, 7'h00, 7'h40};
      {seed, n_mismatch, tests_run, pulses} = {32'h3f4ce134, 96'h0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(CR, 32'h0);
      rchk(EN, 32'h0);
      apb(1'b1, EN, 32'hffffffff);
      rchk(EN, 32'h68);
      apb(1'b1, CR, 32'hfffffffd);
      rchk(CR, 32'h1);
      apb(1'b0, 16'h0f20, 32'h0);
      chk({rd[31:1], err}, 32'h1);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, `LIC_TEST_SEL_ADDR, 32'(s));
         p0 = pulses;
         for (int k = 0; k < 3; k++) begin
            apb(1'b1, CR, k == 0 ? 32'h0 : 32'h2);
            repeat (40) @(posedge pclk);
         end
         chk(32'(pulses - p0), 32'(s == 4));
      end
      rchk(`LIC_TEST_SEL_ADDR, 32'h7);
      for (int k = 0; k < 2; k++) begin
         drive_monitor_status <= ~drive_monitor_status;
         repeat (8) @(posedge pclk);
         clr(32'h40);
      end
      ja_rd_ptr <= seed[6:0];
      ja_wr_ptr <= seed[6:0] + 7'h04;
      repeat (4) @(posedge pclk);
      rchk(ST, 32'h0);
      ja_wr_ptr <= ja_rd_ptr - 7'h03;
      repeat (4) @(posedge pclk);
      clr(32'h20);
      rchk(`LIC_LIVE_STAT_ADDR, 32'h20);
      loop_code_match <= 1'b1;
      repeat (PERSIST - 4) @(posedge pclk);
      chk({31'h0, loop_code_detect_status}, 32'h0);
      repeat (12) @(posedge pclk);
      chk({31'h0, loop_code_detect_status}, 32'h1);
      clr(32'h08);
      loop_code_match <= 1'b0;
      repeat (8) @(posedge pclk);
      clr(32'h08);
      apb(1'b1, EN, 32'h0);
      drive_monitor_status <= ~drive_monitor_status;
      repeat (8) @(posedge pclk);
      clr(32'h0);
      apb(1'b1, EN, 32'h68);
      single_rail_mode <= 1'b0;
      repeat (4) @(posedge pclk);
      drive_monitor_status <= ~drive_monitor_status;
      repeat (8) @(posedge pclk);
      clr(32'h0);
      wrap_up;
   end
endmodule // line_iface_test_and_irq_enables_test
`default_nettype wire
